// ### selector_cfg.svh
// Purpose: Constants of the selector switch monitor
// Assumes: 100 MHz system clock
// Notes:   Offsets are APB byte addresses
`ifndef SELECTOR_CFG_SVH
`define SELECTOR_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SSM_CLK_MHZ       100
`define SSM_SCAN_US       1000
`define SSM_SCAN_CYC      (`SSM_SCAN_US * `SSM_CLK_MHZ)
`define SSM_FAULT_MS      2000
`define SSM_FAULT_SCANS   ((`SSM_FAULT_MS * 1000) / `SSM_SCAN_US)

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define SSM_OFS_CTRL      12'h000
`define SSM_OFS_STATUS    12'h004
`define SSM_OFS_IRQ_STAT  12'h008
`define SSM_OFS_IRQ_MASK  12'h00C

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define SSM_CTRL_CNT_LSB  0
`define SSM_CTRL_CNT_MSB  3
`define SSM_CTRL_IND_BIT  4
`define SSM_CNT_RST       4'h2
`define SSM_CNT_MIN       4'h2
`define SSM_CNT_MAX       4'h8
`define SSM_ST_FAULT_BIT  8
`define SSM_ST_MULTI_BIT  9
`define SSM_ST_NONE_BIT   10
`define SSM_ST_IND_BIT    11
`define SSM_IRQ_FAULT     0
`define SSM_IRQ_CLEAR     1
`define SSM_IRQ_SEL       2
`define SSM_IRQ_RST       3'h0
`define SSM_MASK_RST      3'h0

`endif

// ### selector_pkg.sv
// Purpose: Types and helpers of the selector switch monitor
// Assumes: Up to eight contacts
// Notes:   None
package selector_pkg;

    typedef logic [7:0] lane_type;

    typedef enum logic [1:0] {PAT_SINGLE, PAT_NONE, PAT_MULTI} pat_type;

    function automatic logic [3:0] count_ones(input lane_type v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++)
        begin
            n = n + {3'h0, v[i]};
        end
        return n;
    endfunction

    function automatic lane_type lane_mask(input logic [3:0] cnt);
        lane_type m;
        m = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            m[i] = (4'(i) < cnt);
        end
        return m;
    endfunction

endpackage

// ### sel_timer_if.sv
// Purpose: Link between monitor and persistence timer
// Assumes: One clock domain
// Notes:   tick is the once per scan enable
`timescale 1ns/1ps
interface sel_timer_if;
    logic tick;
    logic run;
    logic restart;
    logic at_limit;

    modport mon (output tick, output run, output restart, input at_limit);
    modport tmr (input tick, input run, input restart, output at_limit);
endinterface

// ### hold_timer.sv
// Purpose: Counts scans for which a bad contact pattern persists
// Assumes: tick is a one-cycle pulse per scan
// Notes:   Saturates at the limit
`timescale 1ns/1ps
module hold_timer #(
    parameter int unsigned LIMIT = 2000
) (
    input  wire logic      clk_i,
    input  wire logic      nrst_i,
    sel_timer_if.tmr       tif
);
    import selector_pkg::*;

    logic [15:0] count_r;

    // ----------------------------------------------------------------
    // Scan counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            count_r <= 16'h0000;
        else if (tif.tick)
        begin
            if (tif.restart || !tif.run)
                count_r <= 16'h0000;
            else if (count_r < 16'(LIMIT))
                count_r <= count_r + 16'h0001;
        end
    end

    assign tif.at_limit = (count_r >= 16'(LIMIT));

    AST_RESTART: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (tif.tick && tif.restart) |=> (count_r == 16'h0000))
        else $error("timer did not restart");

    AST_SATURATE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (count_r <= 16'(LIMIT)))
        else $error("timer ran past limit");

endmodule // hold_timer

// ### selector_switch_monitor.sv
// Purpose: One-of-N selector switch monitor with APB registers
// Assumes: Contacts are asynchronous pins; 100 MHz clock
// Notes:   Evaluated once per scan tick
// Contract
// - Contact and output count is settable from two to eight, default two.
// - With exactly one contact k on and no fault, output k is on and all others off.
// - While a fault is present every output is off.
// - Two or more contacts on together for longer than two seconds is a fault.
// - All contacts off for longer than two seconds is a fault.
// - An enabled fault indicator is on while a fault is present.
// - A fault clears only when exactly one contact is on again.
// - With contacts coming on in different scans, the first one keeps its output on.
// - Two or more contacts coming on in the same scan turn all outputs off at once.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "selector_cfg.svh"
module selector_switch_monitor #(
    parameter int unsigned SCAN_CYCLES = `SSM_SCAN_CYC,
    parameter int unsigned FAULT_SCANS = `SSM_FAULT_SCANS
) (
    input  wire logic                 clk_i,
    input  wire logic                 nrst_i,
    input  wire logic                 psel_i,
    input  wire logic                 penable_i,
    input  wire logic                 pwrite_i,
    input  wire logic [11:0]          paddr_i,
    input  wire logic [31:0]          pwdata_i,
    output logic      [31:0]          prdata_o,
    output logic                      pready_o,
    output logic                      pslverr_o,
    input  wire selector_pkg::lane_type contact_i,
    output selector_pkg::lane_type    sel_o,
    output logic                      fault_ind_o,
    output logic                      irq_o
);
    import selector_pkg::*;

    function automatic logic reg_known(input logic [11:0] a);
        return (a == `SSM_OFS_CTRL) || (a == `SSM_OFS_STATUS) ||
               (a == `SSM_OFS_IRQ_STAT) || (a == `SSM_OFS_IRQ_MASK);
    endfunction

    lane_type    sync1_r;
    lane_type    sync2_r;
    lane_type    prev_r;
    lane_type    owner_r;
    lane_type    sel_r;
    lane_type    cur;
    lane_type    owner_nxt;
    pat_type     pat_r;
    pat_type     pat_nxt;
    logic [19:0] div_r;
    logic        tick_r;
    logic [3:0]  cnt_r;
    logic        ind_en_r;
    logic        fault_r;
    logic        fault_nxt;
    logic        ind_r;
    logic [3:0]  ones;
    logic [3:0]  new_ones;
    logic [2:0]  irq_stat_r;
    logic [2:0]  irq_mask_r;
    logic [2:0]  events;
    logic        irq_r;
    logic        access;
    logic        stat_rd;
    logic        pready_r;
    logic        pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] status_word;
    logic [3:0]  wr_cnt;

    sel_timer_if tif ();

    // ----------------------------------------------------------------
    // Contact synchroniser and scan divider
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            sync1_r <= 8'h00;
            sync2_r <= 8'h00;
        end
        else
        begin
            sync1_r <= contact_i;
            sync2_r <= sync1_r;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            div_r  <= 20'h0_0000;
            tick_r <= 1'b0;
        end
        else if (div_r == 20'(SCAN_CYCLES - 1))
        begin
            div_r  <= 20'h0_0000;
            tick_r <= 1'b1;
        end
        else
        begin
            div_r  <= div_r + 20'h0_0001;
            tick_r <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Pattern evaluation
    // ----------------------------------------------------------------
    // Lanes above the configured count are ignored
    assign cur      = sync2_r & lane_mask(cnt_r);
    assign ones     = count_ones(cur);
    assign new_ones = count_ones(cur & ~prev_r);

    always_comb
    begin
        if (ones == 4'h0)
            pat_nxt = PAT_NONE;
        else if (ones == 4'h1)
            pat_nxt = PAT_SINGLE;
        else
            pat_nxt = PAT_MULTI;
    end

    assign tif.tick    = tick_r;
    assign tif.run     = (pat_nxt != PAT_SINGLE);
    assign tif.restart = (pat_nxt != pat_r);

    hold_timer #(.LIMIT(FAULT_SCANS)) u_timer (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .tif    (tif)
    );

    always_comb
    begin
        owner_nxt = 8'h00;
        case (pat_nxt)
            PAT_SINGLE: owner_nxt = cur;
            PAT_NONE:   owner_nxt = 8'h00;
            PAT_MULTI:
            begin
                if (new_ones >= 4'h2)
                    owner_nxt = 8'h00;
                else if ((owner_r & cur) != 8'h00)
                    owner_nxt = owner_r;
                else
                    owner_nxt = 8'h00;
            end
            default:    owner_nxt = 8'h00;
        endcase
    end

    always_comb
    begin
        fault_nxt = fault_r;
        if (tick_r)
        begin
            if (pat_nxt == PAT_SINGLE)
                fault_nxt = 1'b0;
            else if (!tif.restart && tif.at_limit)
                fault_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            prev_r  <= 8'h00;
            owner_r <= 8'h00;
            pat_r   <= PAT_NONE;
            fault_r <= 1'b0;
            sel_r   <= 8'h00;
        end
        else if (tick_r)
        begin
            prev_r  <= cur;
            owner_r <= owner_nxt;
            pat_r   <= pat_nxt;
            fault_r <= fault_nxt;
            sel_r   <= fault_nxt ? 8'h00 : owner_nxt;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
            ind_r <= 1'b0;
        else
            ind_r <= fault_r & ind_en_r;
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // One wait state keeps every bus output on a flop
    assign access  = psel_i & penable_i & ~pready_r;
    assign stat_rd = access & ~pwrite_i & (paddr_i == `SSM_OFS_IRQ_STAT);
    assign wr_cnt  = pwdata_i[`SSM_CTRL_CNT_MSB:`SSM_CTRL_CNT_LSB];

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[7:0] = sel_r;
        status_word[`SSM_ST_FAULT_BIT] = fault_r;
        status_word[`SSM_ST_MULTI_BIT] = (pat_r == PAT_MULTI);
        status_word[`SSM_ST_NONE_BIT] = (pat_r == PAT_NONE);
        status_word[`SSM_ST_IND_BIT] = ind_r;
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            cnt_r      <= `SSM_CNT_RST;
            ind_en_r   <= 1'b0;
            irq_mask_r <= `SSM_MASK_RST;
        end
        else if (access && pwrite_i)
        begin
            if (paddr_i == `SSM_OFS_CTRL)
            begin
                // Out of range counts clamp to the legal span
                if (wr_cnt < `SSM_CNT_MIN)
                    cnt_r <= `SSM_CNT_MIN;
                else if (wr_cnt > `SSM_CNT_MAX)
                    cnt_r <= `SSM_CNT_MAX;
                else
                    cnt_r <= wr_cnt;
                ind_en_r <= pwdata_i[`SSM_CTRL_IND_BIT];
            end
            if (paddr_i == `SSM_OFS_IRQ_MASK)
                irq_mask_r <= pwdata_i[2:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end
        else
        begin
            pready_r  <= access;
            pslverr_r <= access & ~reg_known(paddr_i);
            prdata_r  <= 32'h0000_0000;
            if (access && !pwrite_i)
            begin
                case (paddr_i)
                    `SSM_OFS_CTRL:     prdata_r <= {27'h000_0000, ind_en_r, cnt_r};
                    `SSM_OFS_STATUS:   prdata_r <= status_word;
                    `SSM_OFS_IRQ_STAT: prdata_r <= {29'h000_0000, irq_stat_r};
                    `SSM_OFS_IRQ_MASK: prdata_r <= {29'h000_0000, irq_mask_r};
                    default:           prdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign events[`SSM_IRQ_FAULT] = tick_r & fault_nxt & ~fault_r;
    assign events[`SSM_IRQ_CLEAR] = tick_r & ~fault_nxt & fault_r;
    assign events[`SSM_IRQ_SEL]   = tick_r & ((fault_nxt ? 8'h00 : owner_nxt) != sel_r);

    always_ff @(posedge clk_i)
    begin
        if (!nrst_i)
        begin
            irq_stat_r <= `SSM_IRQ_RST;
            irq_r      <= 1'b0;
        end
        else
        begin
            // A new event beats the read clear
            irq_stat_r <= (irq_stat_r & ~{3{stat_rd}}) | events;
            irq_r      <= |(irq_stat_r & irq_mask_r);
        end
    end

    assign prdata_o    = prdata_r;
    assign pready_o    = pready_r;
    assign pslverr_o   = pslverr_r;
    assign sel_o       = sel_r;
    assign fault_ind_o = ind_r;
    assign irq_o       = irq_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_FAULT_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
        fault_r |-> (sel_r == 8'h00))
        else $error("output on during fault");

    AST_ONE_HOT: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $onehot0(sel_r) && (!$past(tick_r) || (sel_r & ~lane_mask($past(cnt_r))) == 8'h00))
        else $error("outputs not one-hot in range");

    AST_SINGLE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (tick_r && ones == 4'h1) |=> (sel_r == $past(cur)) && !fault_r)
        else $error("single contact not mirrored");

    AST_SAME_SCAN: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (tick_r && new_ones >= 4'h2 && ones >= 4'h2) |=> (sel_r == 8'h00))
        else $error("same scan multi not off");

    AST_FIRST_KEEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (tick_r && ones >= 4'h2 && new_ones < 4'h2 && (owner_r & cur) != 8'h00
         && !fault_nxt) |=> (sel_r == $past(owner_r)))
        else $error("first contact lost");

    AST_MULTI_TIME: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ($rose(fault_r) && pat_r == PAT_MULTI) |-> $past(tif.at_limit && !tif.restart))
        else $error("multi fault too early");

    AST_NONE_TIME: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ($rose(fault_r) && pat_r == PAT_NONE) |-> $past(tif.at_limit && !tif.restart))
        else $error("none fault too early");

    AST_CLEAR_CAUSE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(fault_r) |-> (pat_r == PAT_SINGLE))
        else $error("fault cleared without single contact");

    AST_INDICATOR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        (fault_r && ind_en_r) [*2] |-> fault_ind_o)
        else $error("indicator not on during fault");

    AST_TICK_RATE: assert property (@(posedge clk_i) disable iff (!nrst_i)
        tick_r |=> !tick_r)
        else $error("scan tick longer than one cycle");

endmodule // selector_switch_monitor

// ### selector_switch_model.sv
// Purpose: Behavioural multi-position selector switch
// Assumes: Contacts active high, LAG of at least one cycle
// Notes:   Multi-contact positions are only driven when the bench asks
`timescale 1ns/1ps
module selector_switch_model
    import selector_pkg::*;
#(
    parameter int LAG = 1
) (
    input  wire logic     clk_i,
    input  wire lane_type pos_i,
    output lane_type      contact_o
);
    lane_type pipe_r [LAG];

    // ------------------------------------------------------------
    // Mechanical lag
    // ------------------------------------------------------------
    // All lanes move in one cycle, so no stray contact mix appears
    always_ff @(posedge clk_i)
    begin
        pipe_r[0] <= pos_i;
        for (int i = 1; i < LAG; i++)
        begin
            pipe_r[i] <= pipe_r[i-1];
        end
    end

    assign contact_o = pipe_r[LAG-1];
endmodule // selector_switch_model

// ### test_selector_switch_monitor.sv
// Purpose: Self-checking bench of the selector switch monitor
// Assumes: Scan of 4 clocks, fault after 5 scans
// Notes:   Holds keep a scan margin from the fault boundary
`timescale 1ns/1ps
module test_selector_switch_monitor;
    import selector_pkg::*;
    localparam int SC = 4;
    localparam int FS = 5;
    logic        clk_i;
    logic        nrst_i;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata_o;
    logic        pready_o;
    logic        pslverr_o;
    lane_type    pos;
    lane_type    contact;
    lane_type    sel_o;
    logic        fault_ind_o;
    logic        irq_o;
    logic [31:0] rd;
    logic        err;
    logic [31:0] seed;
    int          bad_count, cmp_count;
    int          cnt, owner, fault, cls, acc, prevp, esel, ev, mask, ind;

    selector_switch_monitor #(.SCAN_CYCLES(SC), .FAULT_SCANS(FS)) u_selector_switch_monitor (
        .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(pen),
        .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .contact_i(contact),
        .sel_o(sel_o), .fault_ind_o(fault_ind_o), .irq_o(irq_o));

    selector_switch_model #(.LAG(3)) u_selector_switch_model (
        .clk_i(clk_i), .pos_i(pos), .contact_o(contact));

    // ------------------------------------------------------------
    // Checks and bus tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask

    task automatic chk_sel(input lane_type e, input lane_type g);
        cmp_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] sel_o exp %h got %h", e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (pready_o !== 1'b1 && t < 50);
        if (t >= 50) bad_count++;
        rd = prdata_o;
        err = pslverr_o;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk_val("prdata", e, rd);
    endtask

    // ------------------------------------------------------------
    // Reference model of one held contact pattern
    // ------------------------------------------------------------
    task automatic hold(input int p, input int n);
        int q, ones, nw, c, raw;
        q = p & ((1 << cnt) - 1);
        ones = $countones(q);
        nw = $countones(q & ~prevp);
        c = (ones == 1) ? 0 : (ones == 0) ? 1 : 2;
        acc = (c == cls) ? acc + n : n;
        cls = c;
        if (ones == 1) owner = $clog2(q);
        else if (ones == 0 || nw >= 2 || owner < 0 || ((q >> owner) & 1) == 0) owner = -1;
        raw = (owner >= 0) ? (1 << owner) : 0;
        if (fault != 0 && ones != 1) raw = 0;
        if (raw != esel) ev |= 4;
        if (ones == 1 && fault != 0)
        begin
            fault = 0;
            ev |= 2;
        end
        if (ones != 1 && acc >= FS + 3 && fault == 0)
        begin
            fault = 1;
            ev |= 1;
            if (raw != 0) ev |= 4;
        end
        esel = (fault != 0) ? 0 : raw;
        prevp = q;
        @(posedge clk_i);
        pos <= lane_type'(p);
        repeat (n * SC + 6) @(posedge clk_i);
        chk_sel(lane_type'(esel), sel_o);
        chk_val("fault_ind", fault & ind, fault_ind_o);
        chk_val("irq", 32'((ev & mask) != 0), irq_o);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    initial
    begin
        repeat (50000) @(posedge clk_i);
        bad_count++;
        test_done;
    end

    initial
    begin
        nrst_i = 1'b0;
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pos = 8'h01;
        seed = 32'h0001_6b54;
        // Switch starts in position one, so the first scan selects it
        cnt = 2;
        owner = 0;
        fault = 0;
        cls = 0;
        acc = 0;
        prevp = 1;
        esel = 1;
        ev = 4;
        mask = 0;
        ind = 0;
        bad_count = 0;
        cmp_count = 0;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd_chk(12'h000, 32'h0000_0002);
        rd_chk(12'h00C, 32'h0000_0000);
        rd_chk(12'h010, 32'h0000_0000);
        chk_val("pslverr", 32'h0000_0001, err);
        apb(1'b1, 12'h000, 32'h0000_000F);
        rd_chk(12'h000, 32'h0000_0008);
        apb(1'b1, 12'h000, 32'h0000_0018);
        cnt = 8;
        ind = 1;
        hold(1, 3);
        rd_chk(12'h008, ev);
        ev = 0;
        apb(1'b1, 12'h00C, 32'h0000_0001);
        mask = 1;
        $display("test registers done");
        hold(6, 3);
        hold(2, 3);
        hold(3, 3);
        hold(3, 8);
        rd_chk(12'h004, esel | fault << 8 | (cls == 2) << 9 | (cls == 1) << 10 | (fault & ind) << 11);
        rd_chk(12'h008, ev);
        ev = 0;
        hold(4, 3);
        apb(1'b1, 12'h00C, 32'h0000_0007);
        mask = 7;
        hold(0, 10);
        rd_chk(12'h004, esel | fault << 8 | (cls == 2) << 9 | (cls == 1) << 10 | (fault & ind) << 11);
        rd_chk(12'h008, ev);
        ev = 0;
        hold(1, 3);
        $display("test patterns done");
        // Count changes leave short unmodelled events, so irq is masked here
        apb(1'b1, 12'h00C, 32'h0000_0000);
        mask = 0;
        repeat (6)
        begin
            seed = lfsr(seed);
            cnt = 2 + int'(seed % 7);
            apb(1'b1, 12'h000, 32'(cnt | 16));
            seed = lfsr(seed);
            hold(1 << int'(seed % cnt), 3);
            if (cnt < 8) hold(1 << cnt, 2);
            hold(1 << int'(seed % cnt), 2);
        end
        $display("test random done");
        test_done;
    end
endmodule // test_selector_switch_monitor
